/* File: core/ivc_consts.svh */
// Offsets, field positions, reset values and vector addresses of the
// interrupt vector control block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef IVC_CONSTS_SVH
`define IVC_CONSTS_SVH

// ---------------------------------------------------------------------
// Register map (word addresses on the Avalon-MM slave)
// ---------------------------------------------------------------------
`define IVC_ADDR_W 4
`define IVC_OFS_CONTROL_2 4'h0
`define IVC_OFS_STATUS 4'h1
`define IVC_OFS_MASK 4'h2

// ---------------------------------------------------------------------
// Field positions of interrupt_control_2
// ---------------------------------------------------------------------
`define IVC_BIT_ALT 15
`define IVC_BIT_IRQ_DISABLE_INSTR_ACTIVE 14
`define IVC_BIT_EP2 2
`define IVC_BIT_EP1 1
`define IVC_BIT_EP0 0
`define IVC_CTRL_WMASK 16'h8007
`define IVC_CTRL_RESET 16'h0000

// ---------------------------------------------------------------------
// Vector numbers and table addresses
// ---------------------------------------------------------------------
`define IVC_VEC_DMA_CHANNEL_FIVE_IRQ 7'h45
`define IVC_VEC_RTC 7'h46
`define IVC_VEC_U1E 7'h49
`define IVC_VEC_U2E 7'h4a
`define IVC_VEC_CRC 7'h4b
`define IVC_VEC_DMA_CHANNEL_SIX_IRQ 7'h4c
`define IVC_VEC_DMA_CHANNEL_SEVEN_IRQ 7'h4d
`define IVC_VEC_CAN1 7'h4e
`define IVC_IVT_BASE 24'h000004
`define IVC_ALT_OFFSET 24'h000100
`define IVC_RESET_PC 24'h000000
`define IVC_NUM_SRC 8
`define IVC_NUM_EXT 3

`endif

/* File: core/ivc_pkg.sv */
// Types shared by the interrupt vector control modules.
// Assumes ivc_consts.svh is on the include path.
`include "ivc_consts.svh"
package ivc_pkg;
   // Vector number type
   typedef logic [6:0] ivc_vec_t;
   // Program address type
   typedef logic [23:0] ivc_addr_t;
   // Dispatch states, Gray coded
   typedef enum logic [1:0] {
      IVC_IDLE = 2'b00,
      IVC_FETCH = 2'b01,
      IVC_WAIT = 2'b11
   } ivc_state_e;
endpackage

/* File: core/ivc_edge_detect.sv */
// One external interrupt edge detector with polarity select.
// Assumes an asynchronous pin; synchronises it with two flip-flops.
module ivc_edge_detect (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic pin,
   input wire logic falling_sel,
   output logic edge_pulse
);
   logic sync_a; // First stage, read only by sync_b
   logic sync_b; // Second stage
   logic prev; // Delayed copy for edge compare
   logic [2:0] arm; // Fills once the chain holds real pin values
   // ------------------------------------------------------------------
   // Synchroniser and edge compare
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
         arm <= 3'h0;
      end else begin
         sync_a <= pin;
         sync_b <= sync_a;
         prev <= sync_b;
         arm <= {arm[1:0], 1'b1};
      end
   end
   // Select falling or rising edge; blocked until armed so that a pin
   // idling high gives no false edge after reset
   always_comb begin
      if (falling_sel) begin
         edge_pulse = arm[2] & prev & ~sync_b;
      end else begin
         edge_pulse = arm[2] & ~prev & sync_b;
      end
   end
endmodule

/* File: core/ivc_vector_lookup.sv */
// Vector number to table entry address mapping.
// Assumes the alternate select comes from the control register.
`include "ivc_consts.svh"
module ivc_vector_lookup (
   input wire ivc_pkg::ivc_vec_t vec,
   input wire logic alt_table_select,
   output ivc_pkg::ivc_addr_t entry_addr
);
   ivc_pkg::ivc_addr_t base; // Primary table entry
   // Entry sits two words per vector after the table base
   always_comb begin
      base = `IVC_IVT_BASE + {16'h0000, vec, 1'b0};
      if (alt_table_select) begin
         entry_addr = base + `IVC_ALT_OFFSET;
      end else begin
         entry_addr = base;
      end
   end
endmodule

/* File: core/ivc_top.sv */
// Interrupt vector control: second control register, external edge
// polarity, vector address dispatch for the upper sources.
// Assumes a core that fetches entries and an Avalon-MM master.
`include "ivc_consts.svh"

// Functional notes
// - Device reset clears registers, PC forced zero
// - Reset bypasses vector dispatch entirely
// - Core starts fetching at address zero
// - DMA five vector at 8E or 18E
// - Clock interrupt vector at 90 or 190
// - CRC vector at 9A or 19A
// - DMA six vector at 9C or 19C
// - DMA seven vector at 9E or 19E
// - CAN transmit vector at A0 or 1A0
// - External 1,2 polarity: one falling, zero rising
// - Bits 13 to 3 read zero
// - Bit 0 polarity for external zero
// - Alternate select moves all vectors to second table
// - External zero polarity: one falling
// - Each entry holds a 24-bit address
// - Lower address wins at equal level
module ivc_top #(
   parameter int NUM_SRC = `IVC_NUM_SRC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [`IVC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [NUM_SRC-1:0] src_irq,
   input wire logic [`IVC_NUM_EXT-1:0] ext_irq_pin,
   input wire logic irq_disable_instr_active_counting,
   input wire logic vec_ack,
   output logic vec_req,
   output ivc_pkg::ivc_vec_t vec_num,
   output ivc_pkg::ivc_addr_t vec_addr,
   output logic [23:0] reset_pc,
   output logic irq
);
   // Source order in src_irq: dma_channel_five_irq rtc u1e u2e crc dma_channel_six_irq dma_channel_seven_irq can1
   logic alt_table_select; // Alternate table select
   logic irq_disable_instr_active; // Status copy of the disable count
   logic ext_irq0_polarity; // External 0 edge polarity
   logic ext_irq1_polarity; // External 1 edge polarity
   logic ext_irq2_polarity; // External 2 edge polarity
   logic [`IVC_NUM_EXT-1:0] ext_edge; // Edge pulses
   logic [`IVC_NUM_EXT-1:0] ext_status; // Sticky edge events
   logic [`IVC_NUM_EXT-1:0] ext_mask; // Enables of edge events
   logic [NUM_SRC-1:0] pend; // Latched source requests
   ivc_pkg::ivc_state_e state; // Dispatch state
   ivc_pkg::ivc_vec_t next_vec; // Winning vector
   logic next_valid; // A source is pending
   ivc_pkg::ivc_addr_t lookup_addr; // Entry address of winner
   logic [15:0] ctrl_rd; // Read image of control register
   logic bus_pending; // Access served on the next edge
   logic wr_ctrl, wr_stat, wr_mask; // Write strobes

   // ------------------------------------------------------------------
   // Edge detectors
   // ------------------------------------------------------------------
   logic [`IVC_NUM_EXT-1:0] pol_vec;
   assign pol_vec = {ext_irq2_polarity, ext_irq1_polarity,
                     ext_irq0_polarity};
   genvar gi;
   generate
      for (gi = 0; gi < `IVC_NUM_EXT; gi++) begin : g_edge
         ivc_edge_detect u_edge (
            .core_clk(core_clk),
            .srst(srst),
            .pin(ext_irq_pin[gi]),
            .falling_sel(pol_vec[gi]),
            .edge_pulse(ext_edge[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Bus slave: one wait cycle, answer on the second edge
   // ------------------------------------------------------------------
   assign wr_ctrl = bus_pending & avs_write &
                    (avs_address == `IVC_OFS_CONTROL_2);
   assign wr_stat = bus_pending & avs_write &
                    (avs_address == `IVC_OFS_STATUS);
   assign wr_mask = bus_pending & avs_write &
                    (avs_address == `IVC_OFS_MASK);

   // Waitrequest drops for one cycle after a request is seen
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bus_pending <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else if (bus_pending) begin
         bus_pending <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else if (avs_read | avs_write) begin
         bus_pending <= 1'b1;
         avs_waitrequest <= 1'b0;
      end
   end

   // Control register image, unimplemented bits zero
   always_comb begin
      ctrl_rd = 16'h0000;
      ctrl_rd[`IVC_BIT_ALT] = alt_table_select;
      ctrl_rd[`IVC_BIT_IRQ_DISABLE_INSTR_ACTIVE] = irq_disable_instr_active;
      ctrl_rd[`IVC_BIT_EP2] = ext_irq2_polarity;
      ctrl_rd[`IVC_BIT_EP1] = ext_irq1_polarity;
      ctrl_rd[`IVC_BIT_EP0] = ext_irq0_polarity;
   end

   // Read data registered with the answer; unmapped reads zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         avs_readdata <= 32'h00000000;
      end else if (!bus_pending && avs_read) begin
         unique case (avs_address)
            `IVC_OFS_CONTROL_2: avs_readdata <= {16'h0000, ctrl_rd};
            `IVC_OFS_STATUS: avs_readdata <= {29'h0, ext_status};
            `IVC_OFS_MASK: avs_readdata <= {29'h0, ext_mask};
            default: avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         alt_table_select <= 1'b0;
         ext_irq0_polarity <= 1'b0;
         ext_irq1_polarity <= 1'b0;
         ext_irq2_polarity <= 1'b0;
      end else if (wr_ctrl) begin
         alt_table_select <= avs_writedata[`IVC_BIT_ALT];
         ext_irq0_polarity <= avs_writedata[`IVC_BIT_EP0];
         ext_irq1_polarity <= avs_writedata[`IVC_BIT_EP1];
         ext_irq2_polarity <= avs_writedata[`IVC_BIT_EP2];
      end
   end

   // Status flag follows the core's disable count, writes ignored
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_disable_instr_active <= 1'b0;
      end else begin
         irq_disable_instr_active <= irq_disable_instr_active_counting;
      end
   end

   // ------------------------------------------------------------------
   // Edge event status and mask, set wins over clear
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ext_status <= 3'h0;
      end else begin
         ext_status <= (ext_status &
                        ~(wr_stat ? avs_writedata[2:0] : 3'h0))
                       | ext_edge;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ext_mask <= 3'h0;
      end else if (wr_mask) begin
         ext_mask <= avs_writedata[2:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ext_status & ext_mask);
      end
   end

   // ------------------------------------------------------------------
   // Source vectors and priority
   // ------------------------------------------------------------------
   localparam ivc_pkg::ivc_vec_t SRC_VEC [`IVC_NUM_SRC] = '{
      `IVC_VEC_DMA_CHANNEL_FIVE_IRQ,
      `IVC_VEC_RTC,
      `IVC_VEC_U1E,
      `IVC_VEC_U2E,
      `IVC_VEC_CRC,
      `IVC_VEC_DMA_CHANNEL_SIX_IRQ,
      `IVC_VEC_DMA_CHANNEL_SEVEN_IRQ,
      `IVC_VEC_CAN1
   };

   // Lowest index, hence lowest address, wins
   always_comb begin
      next_vec = 7'h00;
      next_valid = 1'b0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            next_vec = SRC_VEC[i];
            next_valid = 1'b1;
         end
      end
   end

   ivc_vector_lookup u_lookup (
      .vec(next_vec),
      .alt_table_select(alt_table_select),
      .entry_addr(lookup_addr)
   );

   // ------------------------------------------------------------------
   // Pending latch and dispatch toward the core
   // ------------------------------------------------------------------
   logic [NUM_SRC-1:0] served; // One-hot of dispatched source
   always_comb begin
      served = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pend[i] && !(|served)) begin
            served = '0;
         end
      end
      for (int i = 0; i < NUM_SRC; i++) begin
         if (SRC_VEC[i] == vec_num && state == ivc_pkg::IVC_WAIT &&
             vec_ack) begin
            served[i] = 1'b1;
         end
      end
   end

   // New request wins over the clear on acknowledge
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pend <= '0;
      end else begin
         pend <= (pend & ~served) | src_irq;
      end
   end

   // Reset goes straight to the start address, not through vectors
   always_ff @(posedge core_clk) begin
      reset_pc <= `IVC_RESET_PC;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= ivc_pkg::IVC_IDLE;
         vec_req <= 1'b0;
         vec_num <= 7'h00;
         vec_addr <= 24'h000000;
      end else begin
         unique case (state)
            ivc_pkg::IVC_IDLE: begin
               if (next_valid) begin
                  state <= ivc_pkg::IVC_FETCH;
               end
            end
            ivc_pkg::IVC_FETCH: begin
               vec_num <= next_vec;
               vec_addr <= lookup_addr;
               vec_req <= 1'b1;
               state <= ivc_pkg::IVC_WAIT;
            end
            ivc_pkg::IVC_WAIT: begin
               if (vec_ack) begin
                  vec_req <= 1'b0;
                  state <= ivc_pkg::IVC_IDLE;
               end
            end
            default: state <= ivc_pkg::IVC_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_alt_addr: assert property (@(posedge core_clk) disable iff (srst)
      $rose(vec_req) && vec_num == 7'h45 |->
      vec_addr == (alt_table_select ? 24'h00018e : 24'h00008e))
      else $error("dma five vector address wrong");
   a_rtc_addr: assert property (@(posedge core_clk) disable iff (srst)
      $rose(vec_req) && vec_num == 7'h46 |->
      vec_addr[7:0] == 8'h90)
      else $error("clock vector address wrong");
   a_crc_addr: assert property (@(posedge core_clk) disable iff (srst)
      $rose(vec_req) && vec_num == 7'h4b |-> vec_addr[7:0] == 8'h9a)
      else $error("crc vector address wrong");
   a_can_addr: assert property (@(posedge core_clk) disable iff (srst)
      $rose(vec_req) && vec_num == 7'h4e |-> vec_addr[7:0] == 8'ha0)
      else $error("can vector address wrong");
   a_unimpl_zero: assert property (@(posedge core_clk) disable iff (srst)
      !avs_waitrequest |=> avs_readdata[13:3] == 11'h000)
      else $error("unimplemented bits not zero");
   a_irq_disable_instr_active_follow: assert property (@(posedge core_clk) disable iff (srst)
      irq_disable_instr_active_counting |=> ctrl_rd[`IVC_BIT_IRQ_DISABLE_INSTR_ACTIVE])
      else $error("disable status not shown");
   a_prio_low: assert property (@(posedge core_clk) disable iff (srst)
      next_valid && pend[0] |-> next_vec == 7'h45)
      else $error("lower address lost arbitration");
   a_reset_clear: assert property (@(posedge core_clk)
      srst |=> !alt_table_select && !vec_req && ctrl_rd == 16'h0)
      else $error("reset did not clear state");
   a_req_soon: assert property (@(posedge core_clk) disable iff (srst)
      state == ivc_pkg::IVC_IDLE && next_valid |-> ##[1:2] vec_req)
      else $error("request not issued");
   c_alt: cover property (@(posedge core_clk) vec_req && alt_table_select);
   c_edge: cover property (@(posedge core_clk) |ext_edge);
   c_ack: cover property (@(posedge core_clk) vec_req && vec_ack);
endmodule

/* File: verification/ivc_core_model.sv */
// Behavioural processor core that fetches vector entries from the block.
// Assumes one clock and the synchronous active-high reset of the block.
module ivc_core_model (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic vec_req,
   input wire ivc_pkg::ivc_vec_t vec_num,
   input wire ivc_pkg::ivc_addr_t vec_addr,
   input wire logic [23:0] reset_pc,
   input wire logic [3:0] ack_delay,
   output logic vec_ack,
   output logic [7:0] got_count,
   output ivc_pkg::ivc_vec_t last_num,
   output ivc_pkg::ivc_addr_t pc
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Fetch engine
   // ----------------------------------------------------------------
   logic [3:0] wait_cnt; // Cycles spent before taking a vector

   // Waits ack_delay cycles, then takes the entry for one cycle only
   always_ff @(posedge core_clk) begin
      if (srst) begin
         vec_ack <= 1'b0;
         wait_cnt <= 4'h0;
         got_count <= 8'h00;
         last_num <= 7'h00;
         // Unused table entries are taken to lead back to this address
         pc <= reset_pc;
      end else if (vec_ack) begin
         // Drop acknowledge; the block drops the request on this same edge
         vec_ack <= 1'b0;
      end else if (vec_req) begin
         if (wait_cnt == ack_delay) begin
            vec_ack <= 1'b1;
            wait_cnt <= 4'h0;
            got_count <= got_count + 8'h01;
            last_num <= vec_num;
            pc <= vec_addr;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

/* File: verification/tb_interrupt_vector_control.sv */
// Self-checking bench of the interrupt vector control block.
// Assumes the core model file and the design files are compiled first.
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
   err_count++; $display("unexpected at %0t: %0h not %0h", \
   $time, got, exp); end end
module tb_interrupt_vector_control;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic core_clk, srst, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [7:0] src_irq, got_count;
   logic [2:0] ext_irq_pin;
   logic irq_disable_instr_active_counting, vec_ack, vec_req, irq;
   logic [3:0] ack_delay;
   logic [23:0] reset_pc;
   ivc_pkg::ivc_vec_t vec_num, last_num;
   ivc_pkg::ivc_addr_t vec_addr, pc;
   int err_count = 0; // Mismatches
   int n_tests = 0; // Comparisons

   ivc_top u_dut (.core_clk(core_clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .src_irq(src_irq), .ext_irq_pin(ext_irq_pin),
      .irq_disable_instr_active_counting(irq_disable_instr_active_counting), .vec_ack(vec_ack),
      .vec_req(vec_req), .vec_num(vec_num), .vec_addr(vec_addr),
      .reset_pc(reset_pc), .irq(irq));
   ivc_core_model u_core (.core_clk(core_clk), .srst(srst),
      .vec_req(vec_req), .vec_num(vec_num), .vec_addr(vec_addr),
      .reset_pc(reset_pc), .ack_delay(ack_delay), .vec_ack(vec_ack),
      .got_count(got_count), .last_num(last_num), .pc(pc));

   // Clock of 4 ns
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------
   // Bus and helper tasks
   // ----------------------------------------------------------------
   // One Avalon-MM transfer; held until waitrequest is sampled low
   task automatic bus_xfer(input logic wr, input logic [3:0] a,
                           input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_write <= wr;
      avs_read <= ~wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      if (n >= 20) `CHECK(avs_waitrequest, 1'b0)
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Waits at most 8 cycles for irq to reach a level; the caller compares
   task automatic wait_irq(input logic lvl);
      int n;
      for (n = 0; n < 8 && irq !== lvl; n++) @(posedge core_clk);
   endtask
   // One-cycle pulse on the source lines
   task automatic pulse_src(input logic [7:0] s);
      @(posedge core_clk);
      src_irq <= s;
      @(posedge core_clk);
      src_irq <= 8'h00;
   endtask
   // Waits for the core model to take a vector
   task automatic wait_vec(input logic [7:0] old);
      int n;
      for (n = 0; n < 40 && got_count === old; n++) @(posedge core_clk);
   endtask
   // Verdict and end of run
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Reset in the middle of a pending vector
   task automatic test_reset;
      logic [7:0] old;
      bus_xfer(1'b1, 4'h0, 32'h0000_8007);
      old = got_count;
      pulse_src(8'h01);
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      repeat (10) @(posedge core_clk);
      `CHECK(got_count, 8'h00)
      `CHECK(vec_req, 1'b0)
      `CHECK(pc, 24'h000000)
      `CHECK(reset_pc, 24'h000000)
      bus_xfer(1'b0, 4'h0, 32'h0);
      `CHECK(rd, 32'h0000_0000)
      $display("test_reset done");
   endtask
   // Control register access kinds and unmapped places
   task automatic test_ctrl;
      irq_disable_instr_active_counting <= 1'b1;
      bus_xfer(1'b1, 4'h0, 32'hffff_ffff);
      bus_xfer(1'b0, 4'h0, 32'h0);
      `CHECK(rd, 32'h0000_c007)
      irq_disable_instr_active_counting <= 1'b0;
      bus_xfer(1'b0, 4'h0, 32'h0);
      `CHECK(rd, 32'h0000_8007)
      bus_xfer(1'b1, 4'h3, 32'h0);
      bus_xfer(1'b0, 4'hf, 32'h0);
      `CHECK(rd, 32'h0000_0000)
      bus_xfer(1'b0, 4'h0, 32'h0);
      `CHECK(rd, 32'h0000_8007)
      $display("test_ctrl done");
   endtask
   // Every source through both tables, with varied acknowledge delay
   task automatic test_vectors;
      logic [6:0] nums [8] = '{7'h45, 7'h46, 7'h49, 7'h4a,
                               7'h4b, 7'h4c, 7'h4d, 7'h4e};
      logic [23:0] adrs [8] = '{24'h00008e, 24'h000090, 24'h000096,
         24'h000098, 24'h00009a, 24'h00009c, 24'h00009e, 24'h0000a0};
      logic [7:0] old;
      for (int alt = 0; alt < 2; alt++) begin
         bus_xfer(1'b1, 4'h0, alt ? 32'h0000_8000 : 32'h0);
         for (int i = 0; i < 8; i++) begin
            ack_delay <= 4'(i % 3);
            old = got_count;
            pulse_src(8'h01 << i);
            wait_vec(old);
            `CHECK(last_num, nums[i])
            `CHECK(pc, adrs[i] + (alt ? 24'h000100 : 24'h0))
         end
      end
      $display("test_vectors done");
   endtask
   // Two sources at once: lower table address goes first
   task automatic test_priority;
      logic [7:0] old;
      bus_xfer(1'b1, 4'h0, 32'h0);
      ack_delay <= 4'h5;
      old = got_count;
      pulse_src(8'h11);
      wait_vec(old);
      `CHECK(last_num, 7'h45)
      wait_vec(old + 8'h01);
      `CHECK(last_num, 7'h4b)
      `CHECK(pc, 24'h00009a)
      $display("test_priority done");
   endtask
   // Edge polarity per pin, masking and write-one-to-clear status
   task automatic test_edges;
      int n;
      for (int i = 0; i < 3; i++) begin
         for (int p = 0; p < 2; p++) begin
            ext_irq_pin[i] <= ~p[0];
            bus_xfer(1'b1, 4'h2, 32'h0);
            bus_xfer(1'b1, 4'h0, 32'(p) << i);
            repeat (4) @(posedge core_clk);
            bus_xfer(1'b1, 4'h1, 32'h7);
            ext_irq_pin[i] <= p[0];
            repeat (8) @(posedge core_clk);
            bus_xfer(1'b0, 4'h1, 32'h0);
            `CHECK(rd[2:0], 3'h0)
            ext_irq_pin[i] <= ~p[0];
            n = 0;
            do begin
               bus_xfer(1'b0, 4'h1, 32'h0);
               n++;
            end while (rd[i] !== 1'b1 && n < 8);
            `CHECK(rd[2:0], 3'(1 << i))
            `CHECK(irq, 1'b0)
            bus_xfer(1'b1, 4'h2, 32'(1) << i);
            wait_irq(1'b1);
            `CHECK(irq, 1'b1)
            bus_xfer(1'b1, 4'h1, 32'(1) << i);
            wait_irq(1'b0);
            `CHECK(irq, 1'b0)
         end
      end
      $display("test_edges done");
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      srst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      src_irq = 8'h00;
      ext_irq_pin = 3'h0;
      irq_disable_instr_active_counting = 1'b0;
      ack_delay = 4'h0;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      test_reset();
      test_ctrl();
      test_vectors();
      test_priority();
      test_edges();
      finish_test();
   end
   // Cuts a hang short after far more than the tests need
   initial begin
      #80000;
      err_count++;
      finish_test();
   end
endmodule
